// File: core/vpl_defines.svh
// constants for the vpw link error and delay control block
`ifndef VPL_DEFINES_SVH
`define VPL_DEFINES_SVH

// register byte offsets
`define VPL_OFS_DLY      8'h00
`define VPL_OFS_CTL1     8'h04
`define VPL_OFS_SVR      8'h08
`define VPL_OFS_TXCMD    8'h0c
`define VPL_OFS_STAT     8'h10

// transceiver delay comp fields
`define VPL_DLY_XCVR_BIT 7
`define VPL_DLY_POL_BIT  6
`define VPL_DLY_CODE_RST 4'h7
`define VPL_DLY_POL_RST  1'b1
`define VPL_DLY_XCVR_RST 1'b0

// link control one fields
`define VPL_CTL_IGN_BIT  0
`define VPL_CTL_IE_BIT   1

// status register fields
`define VPL_ST_INV_BIT   0
`define VPL_ST_LOA_BIT   1
`define VPL_ST_STUCK_BIT 2
`define VPL_ST_PEND_BIT  3

// state vector codes
`define VPL_SV_NONE      8'h00
`define VPL_SV_CRC       8'h18
`define VPL_SV_INVSYM    8'h1c
`define VPL_SV_TXERR     8'h20
`define VPL_SV_PASS      8'h20

// timing
`define VPL_CLK_MHZ      20
`define VPL_DLY_BASE_US  9
`define VPL_STUCK_US     2000
`define VPL_STUCK_CYC    (`VPL_STUCK_US * `VPL_CLK_MHZ)

`endif

// File: core/vpl_pkg.sv
// types for the vpw link error and delay control block
package vpl_pkg;

    // symbol classes reported by the symbol decoder
    typedef enum logic [2:0] {
        SK_SOF,
        SK_BIT,
        SK_EOD,
        SK_EOF,
        SK_BREAK,
        SK_INVALID,
        SK_IDLE
    } vpl_sym_e;

    // error handling states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_TX_SOF,
        ST_FRAME,
        ST_WAIT_EOF,
        ST_WAIT_IDLE,
        ST_WAIT_SOF
    } vpl_state_e;

endpackage

// File: core/vpl_rx_cond.sv
// receive pin synchroniser with polarity selection
`timescale 1ns/100ps
`default_nettype none

module vpl_rx_cond (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic rx_pin,
    input  wire logic receive_polarity,
    output logic      bus_active
);

    logic sync1_ff;   // first stage, read only by stage two
    logic sync2_ff;   // second stage
    logic sync3_ff;   // third stage
    logic level_ff;   // filtered pin level

    // three stage synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= rx_pin;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // level follows only when stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_ff <= 1'b0;
        end else if (sync2_ff == sync3_ff) begin
            level_ff <= sync3_ff;
        end
    end

    // inverting transceivers need the level flipped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_active <= 1'b0;
        end else begin
            bus_active <= receive_polarity ? level_ff : ~level_ff;
        end
    end

endmodule

`default_nettype wire

// File: core/vpl_err_ctrl.sv
// bus error handling, delay compensation and ignore-message control
`timescale 1ns/100ps
`default_nettype none
`include "vpl_defines.svh"

// Overview of operation
// - off-boundary eod or eof is framing error
// - active symbol during own eod is framing
// - bus held active defers any transmission
// - no sof drive: tx error, idle till command
// - faults gone means normal operation resumes
// - break raises invalid symbol, svr read clears
// - after break wait idle then sof
// - break recognised on receive, never sent
// - own transmit error: invalid symbol, stop
// - crc mismatch: crc irq, wait for eof
// - noise while sending aborts at once
// - framing error: invalid symbol, wait eof
// - stuck high: invalid symbol, eof, maybe loa
// - stuck low: invalid symbol flag, need eof
// - delay default 16 us, 9 to 24
// - delay register written once per reset
// - transceiver select 1 onchip, 0 external
// - receive polarity 1 true, 0 inverted
// - delay code maps linearly to microseconds
// - ignore masks irqs except tx error, holds status, discards
// - ignore clears on sof or break
// - irq enable gates requests, pending persists
module vpl_err_ctrl #(
    parameter int STUCK_CYC = `VPL_STUCK_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        rx_pin,
    input  wire logic        sym_valid,
    input  wire vpl_pkg::vpl_sym_e sym_kind,
    input  wire logic        sym_on_boundary,
    input  wire logic        crc_fail,
    input  wire logic        tx_start,
    input  wire logic        tx_sending_eod,
    input  wire logic        tx_bad_bit,
    output logic             bus_active_out,
    output logic             tx_grant,
    output logic             tx_abort,
    output logic             rx_ignore,
    output logic [8:0]       delay_cycles,
    output logic             irq
);

    // delay in cycles for a 4-bit offset code
    function automatic logic [8:0] dly_cyc(input logic [3:0] code);
        logic [8:0] us;
        us = 9'(`VPL_DLY_BASE_US) + {5'h00, code};
        dly_cyc = 9'(us * 9'(`VPL_CLK_MHZ));
    endfunction

    logic               bus_active;     // conditioned receive level
    logic               dphase_ff;      // write data phase pending
    logic [7:0]         waddr_ff;       // latched write address
    logic [3:0]         dcode_ff;       // delay offset code
    logic               dpol_ff;        // receive polarity
    logic               dxcvr_ff;       // onchip transceiver select
    logic               dwritten_ff;    // delay register locked
    logic               ignore_ff;      // ignore message bit
    logic               ie_ff;          // irq enable bit
    logic [7:0]         svr_ff;         // state vector code
    logic               inv_ff;         // invalid symbol status
    logic               loa_ff;         // lost arbitration status
    logic               pend_ff;        // cpu transmission request
    logic [15:0]        stuck_cnt_ff;   // bus active run length
    logic [8:0]         sof_cnt_ff;     // sof drive timeout
    vpl_pkg::vpl_state_e state_ff;      // error handling state
    vpl_pkg::vpl_state_e nxt_state;
    logic               rd_svr;         // svr read in address phase
    logic               addr_ok;        // valid address phase
    logic               wr_dly;         // delay register write
    logic               wr_ctl;         // control register write
    logic               wr_cmd;         // tx command write
    logic               stuck;          // bus stuck active
    logic               sym_act;        // active symbol seen
    logic               err_inv;        // invalid symbol event
    logic               err_crc;        // crc event
    logic               err_tx;         // sof could not be driven
    logic               abort_now;      // stop own transmission
    logic [7:0]         nxt_code;       // code offered this cycle

    vpl_rx_cond u_rx_cond (
        .hclk             (hclk),
        .hresetn          (hresetn),
        .rx_pin           (rx_pin),
        .receive_polarity (dpol_ff),
        .bus_active       (bus_active)
    );

    // bus decode; slave ready with okay in every cycle after reset
    assign addr_ok = hsel && hready && htrans[1];
    assign rd_svr  = addr_ok && !hwrite && (haddr == `VPL_OFS_SVR);
    assign wr_dly  = dphase_ff && (waddr_ff == `VPL_OFS_DLY);
    assign wr_ctl  = dphase_ff && (waddr_ff == `VPL_OFS_CTL1);
    assign wr_cmd  = dphase_ff && (waddr_ff == `VPL_OFS_TXCMD) && hwdata[0];

    // address phase capture of writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase_ff <= 1'b0;
            waddr_ff  <= 8'h00;
        end else begin
            dphase_ff <= addr_ok && hwrite;
            waddr_ff  <= haddr;
        end
    end

    // read data registered at the address phase; unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_ok && !hwrite) begin
                case (haddr)
                    `VPL_OFS_DLY:   hrdata <= {24'h000000, dxcvr_ff, dpol_ff, 2'b00, dcode_ff};
                    `VPL_OFS_CTL1:  hrdata <= {30'h00000000, ie_ff, ignore_ff};
                    `VPL_OFS_SVR:   hrdata <= {24'h000000, svr_ff};
                    `VPL_OFS_STAT:  hrdata <= {28'h0000000, pend_ff, stuck, loa_ff, inv_ff};
                    default:        hrdata <= 32'h0000_0000;
                endcase
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // delay register: one write per reset, then read-only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dcode_ff    <= `VPL_DLY_CODE_RST;
            dpol_ff     <= `VPL_DLY_POL_RST;
            dxcvr_ff    <= `VPL_DLY_XCVR_RST;
            dwritten_ff <= 1'b0;
        end else if (wr_dly && !dwritten_ff) begin
            dcode_ff    <= hwdata[3:0];
            dpol_ff     <= hwdata[`VPL_DLY_POL_BIT];
            dxcvr_ff    <= hwdata[`VPL_DLY_XCVR_BIT];
            dwritten_ff <= 1'b1;
        end
    end

    // delay count handed to the bit timing logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            delay_cycles <= dly_cyc(`VPL_DLY_CODE_RST);
        end else begin
            delay_cycles <= dly_cyc(dcode_ff);
        end
    end

    // control bits; software setting ignore wins over the hardware clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ignore_ff <= 1'b0;
            ie_ff     <= 1'b0;
        end else begin
            if (wr_ctl) begin
                ie_ff <= hwdata[`VPL_CTL_IE_BIT];
            end
            if (wr_ctl && hwdata[`VPL_CTL_IGN_BIT]) begin
                ignore_ff <= 1'b1;
            end else if (sym_valid && (sym_kind == vpl_pkg::SK_SOF ||
                                       sym_kind == vpl_pkg::SK_BREAK)) begin
                ignore_ff <= 1'b0;
            end else if (wr_ctl) begin
                ignore_ff <= 1'b0;
            end
        end
    end

    // bus active run length for stuck detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stuck_cnt_ff <= 16'h0000;
        end else if (!bus_active) begin
            stuck_cnt_ff <= 16'h0000;
        end else if (stuck_cnt_ff != 16'(STUCK_CYC)) begin
            stuck_cnt_ff <= stuck_cnt_ff + 16'h0001;
        end
    end
    assign stuck = (stuck_cnt_ff == 16'(STUCK_CYC));

    // error events; a break is only ever received, nothing here sends one
    assign sym_act = sym_valid && (sym_kind == vpl_pkg::SK_BIT ||
                                   sym_kind == vpl_pkg::SK_SOF);
    assign err_tx  = (state_ff == vpl_pkg::ST_TX_SOF) && !bus_active &&
                     (sof_cnt_ff == 9'h000);
    assign err_crc = crc_fail && (state_ff == vpl_pkg::ST_FRAME);
    assign abort_now = (tx_bad_bit && (state_ff == vpl_pkg::ST_FRAME)) ||
                       err_tx;
    always_comb begin
        err_inv = 1'b0;
        if (sym_valid && (sym_kind == vpl_pkg::SK_EOD || sym_kind == vpl_pkg::SK_EOF) &&
            !sym_on_boundary) begin
            err_inv = 1'b1;
        end
        if (tx_sending_eod && sym_act) begin
            err_inv = 1'b1;
        end
        if (sym_valid && (sym_kind == vpl_pkg::SK_BREAK ||
                          sym_kind == vpl_pkg::SK_INVALID)) begin
            err_inv = 1'b1;
        end
        if (abort_now) begin
            err_inv = 1'b1;
        end
        if (stuck && (stuck_cnt_ff == 16'(STUCK_CYC)) && (state_ff != vpl_pkg::ST_WAIT_EOF)) begin
            err_inv = 1'b1;
        end
    end

    // distinct code per error class
    always_comb begin
        nxt_code = `VPL_SV_NONE;
        if (err_tx) begin
            nxt_code = `VPL_SV_TXERR;
        end else if (err_inv) begin
            nxt_code = `VPL_SV_INVSYM;
        end else if (err_crc) begin
            nxt_code = `VPL_SV_CRC;
        end
    end

    // state vector: higher code wins, a read clears, a new event beats the read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            svr_ff <= `VPL_SV_NONE;
        end else if (ignore_ff && nxt_code != `VPL_SV_PASS) begin
            svr_ff <= `VPL_SV_NONE;
        end else if (nxt_code != `VPL_SV_NONE && (rd_svr || nxt_code >= svr_ff)) begin
            svr_ff <= nxt_code;
        end else if (rd_svr) begin
            svr_ff <= `VPL_SV_NONE;
        end
    end

    // sticky status bits; held at reset while ignoring
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inv_ff <= 1'b0;
            loa_ff <= 1'b0;
        end else if (ignore_ff) begin
            inv_ff <= 1'b0;
            loa_ff <= 1'b0;
        end else begin
            if (err_inv) begin
                inv_ff <= 1'b1;
            end else if (rd_svr) begin
                inv_ff <= 1'b0;
            end
            if (stuck && pend_ff) begin
                loa_ff <= 1'b1;
            end else if (rd_svr) begin
                loa_ff <= 1'b0;
            end
        end
    end

    // cpu transmission request; an abort drops it until the next command
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_ff <= 1'b0;
        end else if (wr_cmd) begin
            pend_ff <= 1'b1;
        end else if (abort_now || (tx_start && tx_grant)) begin
            pend_ff <= 1'b0;
        end
    end

    // sof drive timeout counts the compensated transceiver delay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sof_cnt_ff <= 9'h000;
        end else if (state_ff != vpl_pkg::ST_TX_SOF) begin
            sof_cnt_ff <= delay_cycles;
        end else if (sof_cnt_ff != 9'h000) begin
            sof_cnt_ff <= sof_cnt_ff - 9'h001;
        end
    end

    // error handling sequence
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            vpl_pkg::ST_IDLE: begin
                if (tx_start && tx_grant) begin
                    nxt_state = vpl_pkg::ST_TX_SOF;
                end else if (sym_valid && sym_kind == vpl_pkg::SK_SOF) begin
                    nxt_state = vpl_pkg::ST_FRAME;
                end
            end
            vpl_pkg::ST_TX_SOF: begin
                if (bus_active) begin
                    nxt_state = vpl_pkg::ST_FRAME;
                end else if (err_tx) begin
                    nxt_state = vpl_pkg::ST_WAIT_EOF;
                end
            end
            vpl_pkg::ST_FRAME: begin
                if (err_inv || err_crc) begin
                    nxt_state = vpl_pkg::ST_WAIT_EOF;
                end else if (sym_valid && sym_kind == vpl_pkg::SK_EOF) begin
                    nxt_state = vpl_pkg::ST_IDLE;
                end
            end
            vpl_pkg::ST_WAIT_EOF: begin
                if (sym_valid && sym_kind == vpl_pkg::SK_EOF && !stuck) begin
                    nxt_state = vpl_pkg::ST_IDLE;
                end
            end
            vpl_pkg::ST_WAIT_IDLE: begin
                if (sym_valid && sym_kind == vpl_pkg::SK_IDLE) begin
                    nxt_state = vpl_pkg::ST_WAIT_SOF;
                end
            end
            vpl_pkg::ST_WAIT_SOF: begin
                if (sym_valid && sym_kind == vpl_pkg::SK_SOF) begin
                    nxt_state = vpl_pkg::ST_FRAME;
                end
            end
            default: nxt_state = vpl_pkg::ST_IDLE;
        endcase
        if (sym_valid && sym_kind == vpl_pkg::SK_BREAK) begin
            nxt_state = vpl_pkg::ST_WAIT_IDLE;
        end else if (stuck && state_ff != vpl_pkg::ST_WAIT_IDLE &&
                     state_ff != vpl_pkg::ST_WAIT_SOF) begin
            nxt_state = vpl_pkg::ST_WAIT_EOF;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= vpl_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // registered outputs toward the protocol handler and cpu
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_grant       <= 1'b0;
            tx_abort       <= 1'b0;
            rx_ignore      <= 1'b0;
            bus_active_out <= 1'b0;
            irq            <= 1'b0;
        end else begin
            tx_grant       <= pend_ff && !bus_active && !wr_cmd &&
                              (nxt_state == vpl_pkg::ST_IDLE);
            tx_abort       <= abort_now;
            rx_ignore      <= ignore_ff || (nxt_state == vpl_pkg::ST_WAIT_EOF) ||
                              (nxt_state == vpl_pkg::ST_WAIT_IDLE) ||
                              (nxt_state == vpl_pkg::ST_WAIT_SOF);
            bus_active_out <= bus_active;
            irq            <= ie_ff && (svr_ff != `VPL_SV_NONE) &&
                              (!ignore_ff || svr_ff == `VPL_SV_PASS);
        end
    end

    // no grant while the bus reads active
    a_grant_passive: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_grant |-> $past(!bus_active))
        else $error("grant given while bus active");

    // delay register locks after its first write
    a_dly_once: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(dwritten_ff) |-> $stable(dcode_ff) && $stable(dpol_ff))
        else $error("delay register changed after lock");

    // delay output tracks the code linearly
    a_dly_map: assert property (@(posedge hclk) disable iff (!hresetn)
        delay_cycles == 9'((9'(`VPL_DLY_BASE_US) + {5'h00, $past(dcode_ff)}) * 9'd20))
        else $error("delay cycles do not match code");

    // svr read clears it when no event competes
    a_svr_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_svr && nxt_code == `VPL_SV_NONE && !ignore_ff |=> svr_ff == `VPL_SV_NONE)
        else $error("svr not cleared by read");

    // break leads to waiting for idle bus
    a_break_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        sym_valid && sym_kind == vpl_pkg::SK_BREAK |=> state_ff == vpl_pkg::ST_WAIT_IDLE)
        else $error("break did not enter wait idle");

    // crc failure in a frame gives crc code and waits for eof
    a_crc_code: assert property (@(posedge hclk) disable iff (!hresetn)
        err_crc && !err_inv && !ignore_ff |=> svr_ff >= `VPL_SV_CRC &&
        state_ff == vpl_pkg::ST_WAIT_EOF)
        else $error("crc error not reported");

    // bad bit while sending aborts next cycle
    a_noise_abort: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_bad_bit && state_ff == vpl_pkg::ST_FRAME |=> tx_abort && !pend_ff)
        else $error("noise did not abort transmission");

    // off-boundary eof raises invalid symbol status
    a_frame_err: assert property (@(posedge hclk) disable iff (!hresetn)
        sym_valid && sym_kind == vpl_pkg::SK_EOF && !sym_on_boundary && !ignore_ff
        |=> inv_ff && svr_ff >= `VPL_SV_INVSYM)
        else $error("framing error not flagged");

    // irq off whenever enable is off
    a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        !$past(ie_ff) |-> !irq)
        else $error("irq raised while disabled");

    // ignore holds status at reset value
    a_ign_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(ignore_ff) |-> !inv_ff && !loa_ff)
        else $error("status moved while ignoring");

endmodule

`default_nettype wire

// File: bench/vpl_xcvr_model.sv
// external transceiver stand-in that drives the receive pin
`timescale 1ns/100ps
`default_nettype none
module vpl_xcvr_model (
    input  wire logic short_batt, // bus held active by a short
    input  wire logic inverting,  // transceiver flips the bus level
    output logic      rx_pin      // level seen by the controller
);
    // a grounded bus never shows our own sof, so it reads passive
    assign rx_pin = short_batt ^ inverting;
endmodule
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the vpw link error and delay control block
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic        sym_valid = 1'b0, sym_on_boundary = 1'b0, tx_start = 1'b0;
    logic        crc_fail = 1'b0, tx_sending_eod = 1'b0, tx_bad_bit = 1'b0;
    logic        short_batt = 1'b0, xcvr_inv = 1'b0, hready, hreadyout, hresp, rx_pin;
    logic        bus_active_out, tx_grant, tx_abort, rx_ignore, irq;
    logic [8:0]  delay_cycles;
    vpl_pkg::vpl_sym_e sym_kind = vpl_pkg::SK_IDLE;
    int          fail_count = 0, compares = 0, n, g;
    assign hready = hreadyout; // single slave drives the bus ready
    // 20 mhz clock
    always #25 hclk = ~hclk;
    // short stuck count keeps the run brief
    vpl_err_ctrl #(.STUCK_CYC(50)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .rx_pin,
        .sym_valid, .sym_kind, .sym_on_boundary, .crc_fail, .tx_start,
        .tx_sending_eod, .tx_bad_bit, .bus_active_out, .tx_grant, .tx_abort,
        .rx_ignore, .delay_cycles, .irq);
    vpl_xcvr_model XCVR (.short_batt(short_batt), .inverting(xcvr_inv), .rx_pin(rx_pin));
    // verdict and end of run
    task automatic finish_test;
        $display("mismatches %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic timeout(input string nm);
        chk(nm, 1, 0);
        finish_test();
    endtask
    // bounded wait for ready; zero wait states expected
    task automatic wait_rdy;
        for (n = 0; n < 20; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        timeout("hready");
    endtask
    // one single word transfer; read data lands in rd
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        chk("hresp", 0, hresp);
    endtask
    // one decoded symbol, then let state and outputs settle
    task automatic sym(input vpl_pkg::vpl_sym_e k, input logic b);
        @(posedge hclk);
        sym_valid <= 1'b1;
        sym_kind <= k;
        sym_on_boundary <= b;
        @(posedge hclk);
        sym_valid <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask
    task automatic wait_grant;
        for (n = 0; n < 40; n++) begin
            @(posedge hclk);
            if (tx_grant === 1'b1) return;
        end
        timeout("tx_grant");
    endtask
    // reset values, then the one-shot delay register
    task automatic t_regs;
        chk("delay_cycles", 320, delay_cycles);
        xfer(0, 8'h00, 0);
        chk("dly reset", 32'h47, rd);
        xfer(0, 8'h14, 0);
        chk("unmapped", 0, rd);
        xfer(1, 8'h00, 32'h40);
        xfer(1, 8'h00, 32'h4f);
        xfer(0, 8'h00, 0);
        chk("dly once", 32'h40, rd);
        chk("delay_cycles", 180, delay_cycles);
    endtask
    // bus shorted active: no grant, stuck reported, recovery after eof
    task automatic t_stuck;
        xfer(1, 8'h04, 32'h2);
        @(posedge hclk);
        short_batt <= 1'b1;
        repeat (8) @(posedge hclk);
        chk("bus_active", 1, bus_active_out);
        xfer(1, 8'h0c, 1);
        g = 0;
        for (n = 0; n < 100; n++) begin
            @(posedge hclk);
            if (tx_grant !== 1'b0) g++;
        end
        chk("grant stuck", 0, g);
        xfer(0, 8'h10, 0);
        chk("stat loa stuck", 2'h3, rd[2:1]);
        xfer(0, 8'h08, 0);
        chk("svr stuck", 32'h1c, rd);
        @(posedge hclk);
        short_batt <= 1'b0;
        // the eof only counts once the synchroniser has seen the bus fall
        repeat (8) @(posedge hclk);
        chk("bus passive", 0, bus_active_out);
        sym(vpl_pkg::SK_EOF, 1);
        wait_grant();
    endtask
    // grounded bus: sof never appears, abort after the delay
    task automatic t_gnd;
        @(posedge hclk);
        tx_start <= 1'b1;
        @(posedge hclk);
        tx_start <= 1'b0;
        for (n = 0; n < 400 && tx_abort !== 1'b1; n++) @(posedge hclk);
        if (n == 400) timeout("tx_abort");
        chk("abort wait", 1, n >= 180);
        repeat (2) @(posedge hclk);
        chk("irq", 1, irq);
        xfer(0, 8'h08, 0);
        chk("svr txerr", 32'h20, rd);
        repeat (20) @(posedge hclk);
        chk("irq clear", 0, irq);
        chk("no regrant", 0, tx_grant);
    endtask
    // break, then framing error, then ignore clearing on sof
    task automatic t_rx;
        sym(vpl_pkg::SK_EOF, 1);
        sym(vpl_pkg::SK_BREAK, 1);
        chk("ignore break", 1, rx_ignore);
        xfer(0, 8'h08, 0);
        chk("svr break", 32'h1c, rd);
        xfer(0, 8'h08, 0);
        chk("svr cleared", 0, rd);
        sym(vpl_pkg::SK_SOF, 1);
        chk("ignore no idle", 1, rx_ignore);
        sym(vpl_pkg::SK_IDLE, 1);
        sym(vpl_pkg::SK_SOF, 1);
        chk("ignore sof", 0, rx_ignore);
        sym(vpl_pkg::SK_EOF, 0);
        chk("ignore frame", 1, rx_ignore);
        xfer(0, 8'h08, 0);
        chk("svr frame", 32'h1c, rd);
        sym(vpl_pkg::SK_EOF, 1);
        chk("ignore eof", 0, rx_ignore);
        xfer(1, 8'h04, 32'h3);
        sym(vpl_pkg::SK_SOF, 1);
        xfer(0, 8'h04, 0);
        chk("ctl ignore", 32'h2, rd);
        // noise while sending, frame still open
        @(posedge hclk);
        tx_bad_bit <= 1'b1;
        @(posedge hclk);
        tx_bad_bit <= 1'b0;
        @(posedge hclk);
        chk("noise abort", 1, tx_abort);
        xfer(0, 8'h08, 0);
        chk("svr noise", 32'h1c, rd);
        sym(vpl_pkg::SK_EOF, 1);
        sym(vpl_pkg::SK_SOF, 1);
        @(posedge hclk);
        crc_fail <= 1'b1;
        @(posedge hclk);
        crc_fail <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("crc ignore", 1, rx_ignore);
        chk("crc irq", 1, irq);
        xfer(0, 8'h08, 0);
        chk("svr crc", 32'h18, rd);
        // own eod met by an active symbol
        @(posedge hclk);
        tx_sending_eod <= 1'b1;
        sym(vpl_pkg::SK_BIT, 1);
        tx_sending_eod <= 1'b0;
        xfer(0, 8'h08, 0);
        chk("svr eod", 32'h1c, rd);
    endtask
    // second reset: one more delay write, inverting transceiver
    task automatic t_rst;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(0, 8'h00, 0);
        chk("dly rst", 32'h47, rd);
        xcvr_inv <= 1'b1;
        xfer(1, 8'h00, 32'h05);
        repeat (8) @(posedge hclk);
        chk("bus inverted", 0, bus_active_out);
        xfer(0, 8'h00, 0);
        chk("dly again", 32'h05, rd);
        chk("delay_cycles", 280, delay_cycles);
    endtask
    // reset held three cycles, then the scenarios in turn
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_stuck();
        t_gnd();
        t_rx();
        t_rst();
        finish_test();
    end
endmodule
`default_nettype wire
